// ===== hw/gcfg_top.sv
`timescale 1ns/1ps
module gcfg_top
    import gcfg_pkg::*;
#(
    parameter int IDLE_LONG_CYC  = GCFG_IDLE_LONG_CLKS,
    parameter int IDLE_SHORT_CYC = GCFG_IDLE_SHORT_CLKS
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rstn,
    // register port from the serial host interface
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    input  wire logic [6:0]               reg_addr,
    input  wire logic [31:0]              reg_wdata,
    output logic      [31:0]              reg_rdata,
    // neighbouring register contents
    input  wire logic [31:0]              target_position_reg,
    input  wire logic [GCFG_HOLD_W-1:0]   hold_current_setting,
    // sequencer side
    input  wire logic                     seq_step,
    input  wire logic                     seq_dir,
    input  wire logic [GCFG_COIL_W-1:0]   seq_coil_a,
    input  wire logic [GCFG_COIL_W-1:0]   seq_coil_b,
    output logic                          seq_run,
    output logic                          standstill,
    // step frequency comparison
    input  wire logic [GCFG_FREQ_W-1:0]   step_freq,
    input  wire logic [GCFG_FREQ_W-1:0]   freq_thresh,
    output logic                          freq_above,
    // chopper control
    input  wire logic                     vel_in_pwm_range,
    input  wire logic                     vel_low,
    output logic                          pwm_mode_on,
    output logic                          pwm_velreg_on,
    output logic                          pwm_autoscale_on,
    // coil and direction outputs
    output logic      [GCFG_COIL_W-1:0]   coil_a_out,
    output logic      [GCFG_COIL_W-1:0]   coil_b_out,
    output logic                          dir_out,
    // diagnostic sources
    input  wire logic                     uart_active,
    input  wire logic                     pos_compare,
    input  wire logic                     irq_req,
    // pins
    input  wire logic                     encoder_a_input,
    output logic                          aux_out_zero_pin_o,
    output logic                          aux_out_zero_pin_oe,
    output logic                          aux_out_one_o,
    output logic                          aux_out_one_oe
);
    logic [31:0] global_config_flags;
    logic        enc_meta;
    logic        enc_sync;
    logic        step_gated;
    logic        sig_zero;
    logic        sig_one;
    logic        next_zero_o;
    logic        next_zero_oe;
    logic        next_one_o;
    logic        next_one_oe;
    logic [GCFG_COIL_W-1:0] next_coil_a;
    logic [GCFG_COIL_W-1:0] next_coil_b;
    logic [5:0]              hold_mult;
    logic signed [14:0]      prod_a;
    logic signed [14:0]      prod_b;
    logic [GCFG_FREQ_W-1:0]  hyst;
    logic [GCFG_FREQ_W:0]    upper;
    logic [GCFG_FREQ_W-1:0]  lower;

    gcfg_step_if step_bus ();

    // one address decode shared by read and write paths
    function automatic logic gcfg_hit(input logic [6:0] addr);
        return addr == GCFG_ADDR_FLAGS;
    endfunction : gcfg_hit

    // register write, masked so undefined bits never store
    always_ff @(posedge clk) begin
        if (!rstn) begin
            global_config_flags <= GCFG_RESET_FLAGS;
        end else if (reg_wr && gcfg_hit(reg_addr)) begin
            global_config_flags <= reg_wdata & GCFG_MASK_FLAGS;
        end
    end

    // registered read data, zero for other addresses
    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= GCFG_RD_IDLE;
        end else if (reg_rd && gcfg_hit(reg_addr)) begin
            reg_rdata <= global_config_flags & GCFG_MASK_FLAGS;
        end else begin
            reg_rdata <= GCFG_RD_IDLE;
        end
    end

    // encoder pin is asynchronous: two flops before any use
    always_ff @(posedge clk) begin
        if (!rstn) begin
            enc_meta <= 1'b0;
            enc_sync <= 1'b0;
        end else begin
            enc_meta <= encoder_a_input;
            enc_sync <= enc_meta;
        end
    end

    // hard halt blocks steps at the source, so standstill follows naturally
    always_ff @(posedge clk) begin
        if (!rstn) begin
            seq_run <= 1'b1;
        end else begin
            seq_run <= !(global_config_flags[GCFG_BIT_HALT_EN] && enc_sync);
        end
    end

    assign step_gated = seq_step && seq_run;

    // step stream into pulse shaper and idle timer
    assign step_bus.step       = step_gated;
    assign step_bus.pulse_len  =
        global_config_flags[GCFG_PULSE_MSB:GCFG_PULSE_LSB];
    assign step_bus.quick_idle = global_config_flags[GCFG_BIT_QUICK_IDLE];

    gcfg_step_pulse u_pulse (
        .clk  (clk),
        .rstn (rstn),
        .sp   (step_bus)
    );

    gcfg_idle_timer #(
        .IDLE_LONG_CYC  (IDLE_LONG_CYC),
        .IDLE_SHORT_CYC (IDLE_SHORT_CYC)
    ) u_idle (
        .clk  (clk),
        .rstn (rstn),
        .si   (step_bus)
    );

    always_ff @(posedge clk) begin
        if (!rstn) begin
            standstill <= 1'b0;
        end else begin
            standstill <= step_bus.standstill;
        end
    end

    // direct coil currents, scaled by (hold+1)/32 so 31 is full scale
    assign hold_mult = {1'b0, hold_current_setting} + GCFG_HOLD_ONE;
    // hold_mult reaches 32, so it needs a zero sign bit to stay positive
    assign prod_a = $signed(target_position_reg[GCFG_COIL_A_LSB +: GCFG_COIL_W])
                  * $signed({1'b0, hold_mult});
    assign prod_b = $signed(target_position_reg[GCFG_COIL_B_LSB +: GCFG_COIL_W])
                  * $signed({1'b0, hold_mult});

    always_comb begin
        if (global_config_flags[GCFG_BIT_DIRECT]) begin
            next_coil_a = prod_a[13:5];
            next_coil_b = prod_b[13:5];
        end else begin
            next_coil_a = seq_coil_a;
            next_coil_b = seq_coil_b;
        end
    end

    // coil and direction outputs
    always_ff @(posedge clk) begin
        if (!rstn) begin
            coil_a_out <= '0;
            coil_b_out <= '0;
            dir_out    <= 1'b0;
        end else begin
            coil_a_out <= next_coil_a;
            coil_b_out <= next_coil_b;
            dir_out    <= seq_dir ^ global_config_flags[GCFG_BIT_SHAFT_INV];
        end
    end

    // chopper enables; switching on while moving is left to software
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pwm_mode_on      <= 1'b0;
            pwm_velreg_on    <= 1'b0;
            pwm_autoscale_on <= 1'b0;
        end else begin
            pwm_mode_on   <= global_config_flags[GCFG_BIT_PWM_EN]
                          && vel_in_pwm_range;
            pwm_velreg_on <= global_config_flags[GCFG_BIT_PWM_EN]
                          && !global_config_flags[GCFG_BIT_DIRECT];
            pwm_autoscale_on <= global_config_flags[GCFG_BIT_PWM_EN]
                && (!global_config_flags[GCFG_BIT_DIRECT] || vel_low);
        end
    end

    // frequency comparison with selectable hysteresis band
    assign hyst  = global_config_flags[GCFG_BIT_NARROW_HYST]
                 ? (freq_thresh >> GCFG_HYST_NARROW_SHIFT)
                 : (freq_thresh >> GCFG_HYST_WIDE_SHIFT);
    assign upper = {1'b0, freq_thresh} + {1'b0, hyst};
    assign lower = freq_thresh - hyst;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            freq_above <= 1'b0;
        end else if ({1'b0, step_freq} > upper) begin
            freq_above <= 1'b1;
        end else if (step_freq < lower) begin
            freq_above <= 1'b0;
        end
    end

    // aux function select; UART use leaves aux one idle
    assign sig_zero = global_config_flags[GCFG_BIT_AUX0_FN]
                    ? step_bus.step_level : irq_req;
    assign sig_one  = uart_active ? 1'b0
                    : (global_config_flags[GCFG_BIT_AUX1_FN]
                       ? (seq_dir ^ global_config_flags[GCFG_BIT_SHAFT_INV])
                       : pos_compare);

    // open collector pulls low only while active; push-pull always drives
    always_comb begin
        if (global_config_flags[GCFG_BIT_AUX0_TYPE]) begin
            next_zero_o  = sig_zero;
            next_zero_oe = 1'b1;
        end else begin
            next_zero_o  = 1'b0;
            next_zero_oe = sig_zero;
        end
        if (global_config_flags[GCFG_BIT_AUX1_TYPE]) begin
            next_one_o  = sig_one;
            next_one_oe = 1'b1;
        end else begin
            next_one_o  = 1'b0;
            next_one_oe = sig_one;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            aux_out_zero_pin_o  <= 1'b0;
            aux_out_zero_pin_oe <= 1'b0;
            aux_out_one_o       <= 1'b0;
            aux_out_one_oe      <= 1'b0;
        end else begin
            aux_out_zero_pin_o  <= next_zero_o;
            aux_out_zero_pin_oe <= next_zero_oe;
            aux_out_one_o       <= next_one_o;
            aux_out_one_oe      <= next_one_oe;
        end
    end

    AST_WRITE_READBACK: assert property (@(posedge clk) disable iff (!rstn)
        reg_wr && gcfg_hit(reg_addr) ##1 reg_rd && !reg_wr && gcfg_hit(reg_addr)
        |=> reg_rdata == ($past(reg_wdata, 2) & GCFG_MASK_FLAGS))
        else $error("written value not read back");
    AST_UNDEF_ZERO: assert property (@(posedge clk) disable iff (!rstn)
        (reg_rdata & ~GCFG_MASK_FLAGS) == 32'h00000000)
        else $error("undefined bit read as one");
    AST_HALT: assert property (@(posedge clk) disable iff (!rstn)
        (global_config_flags[GCFG_BIT_HALT_EN] && encoder_a_input)[*4]
        |-> !seq_run)
        else $error("sequencer not halted by encoder input");
    AST_DIRECT_COIL: assert property (@(posedge clk) disable iff (!rstn)
        global_config_flags[GCFG_BIT_DIRECT] && hold_current_setting == 5'h1f
        |=> coil_a_out == $past(target_position_reg[GCFG_COIL_W-1:0]))
        else $error("direct coil A current wrong at full hold");
    AST_SEQ_COIL: assert property (@(posedge clk) disable iff (!rstn)
        !global_config_flags[GCFG_BIT_DIRECT] |=> coil_b_out == $past(seq_coil_b))
        else $error("sequencer coil B current not passed");
    AST_DIR_INV: assert property (@(posedge clk) disable iff (!rstn)
        ##1 dir_out == ($past(seq_dir)
                        ^ $past(global_config_flags[GCFG_BIT_SHAFT_INV])))
        else $error("direction not inverted per config");
    AST_AUX0_PP: assert property (@(posedge clk) disable iff (!rstn)
        global_config_flags[GCFG_BIT_AUX0_TYPE]
        && global_config_flags[GCFG_BIT_AUX0_FN]
        |=> aux_out_zero_pin_oe && aux_out_zero_pin_o == $past(step_bus.step_level))
        else $error("aux zero does not carry step signal");
    AST_AUX0_OC: assert property (@(posedge clk) disable iff (!rstn)
        !global_config_flags[GCFG_BIT_AUX0_TYPE]
        && !global_config_flags[GCFG_BIT_AUX0_FN]
        |=> !aux_out_zero_pin_o && aux_out_zero_pin_oe == $past(irq_req))
        else $error("aux zero open collector wrong");
    AST_AUX1_POS: assert property (@(posedge clk) disable iff (!rstn)
        global_config_flags[GCFG_BIT_AUX1_TYPE] && !uart_active
        && !global_config_flags[GCFG_BIT_AUX1_FN]
        |=> aux_out_one_oe && aux_out_one_o == $past(pos_compare))
        else $error("aux one does not show position compare");
    AST_VELREG_OFF: assert property (@(posedge clk) disable iff (!rstn)
        global_config_flags[GCFG_BIT_DIRECT] |=> !pwm_velreg_on)
        else $error("velocity regulation active in override");
    AST_PWM_EN: assert property (@(posedge clk) disable iff (!rstn)
        !global_config_flags[GCFG_BIT_PWM_EN] |=> !pwm_mode_on)
        else $error("voltage PWM on while disabled");

    COV_HALT: cover property (@(posedge clk) disable iff (!rstn)
        seq_run ##1 !seq_run);
    COV_STANDSTILL: cover property (@(posedge clk) disable iff (!rstn)
        !standstill ##1 standstill);
    COV_DIRECT: cover property (@(posedge clk) disable iff (!rstn)
        global_config_flags[GCFG_BIT_DIRECT] && pwm_autoscale_on);
    COV_HYST: cover property (@(posedge clk) disable iff (!rstn)
        freq_above ##1 !freq_above);
endmodule : gcfg_top

// ===== hw/gcfg_pkg.sv
package gcfg_pkg;
    // register placement and reset
    localparam logic [6:0]  GCFG_ADDR_FLAGS   = 7'h00;
    localparam logic [31:0] GCFG_RESET_FLAGS  = 32'h00000000;
    localparam logic [31:0] GCFG_MASK_FLAGS   = 32'h001ff196;
    localparam logic [31:0] GCFG_RD_IDLE      = 32'h00000000;

    // field positions in global_config_flags
    localparam int GCFG_BIT_QUICK_IDLE   = 1;
    localparam int GCFG_BIT_PWM_EN       = 2;
    localparam int GCFG_BIT_SHAFT_INV    = 4;
    localparam int GCFG_BIT_AUX0_FN      = 7;
    localparam int GCFG_BIT_AUX1_FN      = 8;
    localparam int GCFG_BIT_AUX0_TYPE    = 12;
    localparam int GCFG_BIT_AUX1_TYPE    = 13;
    localparam int GCFG_BIT_NARROW_HYST  = 14;
    localparam int GCFG_BIT_HALT_EN      = 15;
    localparam int GCFG_BIT_DIRECT       = 16;
    localparam int GCFG_PULSE_LSB        = 17;
    localparam int GCFG_PULSE_MSB        = 20;

    // coil fields inside target_position_reg
    localparam int GCFG_COIL_W           = 9;
    localparam int GCFG_COIL_A_LSB       = 0;
    localparam int GCFG_COIL_B_LSB       = 16;
    localparam int GCFG_HOLD_W           = 5;
    localparam logic [5:0] GCFG_HOLD_ONE = 6'h01;

    // step frequency hysteresis shifts: 1/16 and 1/32
    localparam int GCFG_FREQ_W           = 20;
    localparam int GCFG_HYST_WIDE_SHIFT  = 4;
    localparam int GCFG_HYST_NARROW_SHIFT = 5;

    // standstill timeouts, in system clocks
    localparam int GCFG_IDLE_LONG_CLKS   = 2**20;
    localparam int GCFG_IDLE_SHORT_CLKS  = 2**18;
    localparam int GCFG_IDLE_CNT_W       = 21;
    localparam logic [3:0] GCFG_PULSE_TOGGLE = 4'h0;
endpackage : gcfg_pkg

// ===== hw/gcfg_step_if.sv
`timescale 1ns/1ps
interface gcfg_step_if;
    logic       step;
    logic [3:0] pulse_len;
    logic       quick_idle;
    logic       step_level;
    logic       standstill;

    modport ctrl  (output step, pulse_len, quick_idle,
                   input  step_level, standstill);
    modport pulse (input  step, pulse_len, output step_level);
    modport idle  (input  step, quick_idle, output standstill);
endinterface : gcfg_step_if

// ===== hw/gcfg_step_pulse.sv
`timescale 1ns/1ps
module gcfg_step_pulse
    import gcfg_pkg::*;
(
    // clock and reset
    input  wire logic    clk,
    input  wire logic    rstn,
    // step stream
    gcfg_step_if.pulse   sp
);
    logic [3:0] hold_cnt;
    logic       level;

    assign sp.step_level = level;

    // toggle mode or fixed high time per step
    always_ff @(posedge clk) begin
        if (!rstn) begin
            hold_cnt <= 4'h0;
            level    <= 1'b0;
        end else if (sp.step && sp.pulse_len == GCFG_PULSE_TOGGLE) begin
            level    <= ~level;
            hold_cnt <= 4'h0;
        end else if (sp.step) begin
            level    <= 1'b1;
            hold_cnt <= sp.pulse_len;
        end else if (hold_cnt > 4'h1) begin
            hold_cnt <= hold_cnt - 4'h1;
        end else if (hold_cnt == 4'h1) begin
            hold_cnt <= 4'h0;
            level    <= 1'b0;
        end
    end

    AST_PULSE_TOGGLE: assert property (@(posedge clk) disable iff (!rstn)
        sp.step && sp.pulse_len == GCFG_PULSE_TOGGLE |=> level != $past(level))
        else $error("step output did not toggle");
    AST_PULSE_HIGH: assert property (@(posedge clk) disable iff (!rstn)
        sp.step && sp.pulse_len != GCFG_PULSE_TOGGLE
        |=> level && hold_cnt == $past(sp.pulse_len))
        else $error("step pulse not started with programmed length");
    AST_PULSE_END: assert property (@(posedge clk) disable iff (!rstn)
        hold_cnt == 4'h1 && !sp.step |=> !level)
        else $error("step pulse longer than programmed");
endmodule : gcfg_step_pulse

// ===== hw/gcfg_idle_timer.sv
`timescale 1ns/1ps
module gcfg_idle_timer
    import gcfg_pkg::*;
#(
    parameter int IDLE_LONG_CYC  = GCFG_IDLE_LONG_CLKS,
    parameter int IDLE_SHORT_CYC = GCFG_IDLE_SHORT_CLKS
) (
    // clock and reset
    input  wire logic    clk,
    input  wire logic    rstn,
    // step stream
    gcfg_step_if.idle    si
);
    localparam logic [GCFG_IDLE_CNT_W-1:0] LIM_LONG =
        GCFG_IDLE_CNT_W'(IDLE_LONG_CYC);
    localparam logic [GCFG_IDLE_CNT_W-1:0] LIM_SHORT =
        GCFG_IDLE_CNT_W'(IDLE_SHORT_CYC);

    logic [GCFG_IDLE_CNT_W-1:0] idle_cnt;
    logic [GCFG_IDLE_CNT_W-1:0] limit;
    logic                       still;

    assign limit         = si.quick_idle ? LIM_SHORT : LIM_LONG;
    assign si.standstill = still;

    // counter saturates, so a late switch to the short limit still fires
    always_ff @(posedge clk) begin
        if (!rstn) begin
            idle_cnt <= '0;
            still    <= 1'b0;
        end else if (si.step) begin
            idle_cnt <= '0;
            still    <= 1'b0;
        end else if (idle_cnt >= limit) begin
            still    <= 1'b1;
        end else begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end

    AST_IDLE_STEP_CLEARS: assert property (@(posedge clk) disable iff (!rstn)
        si.step |=> !still && idle_cnt == '0)
        else $error("step did not leave standstill");
    AST_IDLE_NOT_EARLY: assert property (@(posedge clk) disable iff (!rstn)
        !$past(still) && still |-> $past(idle_cnt) >= $past(limit))
        else $error("standstill declared before timeout");
endmodule : gcfg_idle_timer

// ===== bench/tb_global_config_register.sv
`timescale 1ns/1ps
module tb_global_config_register;
    import gcfg_pkg::*;
    logic        clk, rstn, reg_wr, reg_rd, seq_step, seq_dir, seq_run;
    logic        standstill, freq_above, vel_in_pwm_range, vel_low;
    logic        pwm_mode_on, pwm_velreg_on, pwm_autoscale_on, dir_out;
    logic        uart_active, pos_compare, irq_req, encoder_a_input;
    logic        aux0_o, aux0_oe, aux1_o, aux1_oe;
    logic [6:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, tpos;
    logic [4:0]  hold;
    logic [8:0]  seq_coil_a, seq_coil_b, coil_a_out, coil_b_out;
    logic [19:0] step_freq, freq_thresh;
    int          fail_count, n_tests, n;

    // short idle limits keep the standstill runs brief
    gcfg_top #(.IDLE_LONG_CYC(64), .IDLE_SHORT_CYC(16)) dut (
        .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .target_position_reg(tpos), .hold_current_setting(hold),
        .seq_step(seq_step), .seq_dir(seq_dir), .seq_coil_a(seq_coil_a),
        .seq_coil_b(seq_coil_b), .seq_run(seq_run), .standstill(standstill),
        .step_freq(step_freq), .freq_thresh(freq_thresh),
        .freq_above(freq_above), .vel_in_pwm_range(vel_in_pwm_range),
        .vel_low(vel_low), .pwm_mode_on(pwm_mode_on),
        .pwm_velreg_on(pwm_velreg_on), .pwm_autoscale_on(pwm_autoscale_on),
        .coil_a_out(coil_a_out), .coil_b_out(coil_b_out), .dir_out(dir_out),
        .uart_active(uart_active), .pos_compare(pos_compare),
        .irq_req(irq_req), .encoder_a_input(encoder_a_input),
        .aux_out_zero_pin_o(aux0_o), .aux_out_zero_pin_oe(aux0_oe),
        .aux_out_one_o(aux1_o), .aux_out_one_oe(aux1_oe));

    // verdict and end of run, shared by the timeouts
    task automatic give_verdict;
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // a bound that runs out is a mismatch and ends the run
    task automatic bound_hit(input int lim);
        if (n >= lim) begin
            fail_count++;
            $display("mismatch at %0t: wait bound exhausted", $time);
            give_verdict();
        end
    endtask : bound_hit

    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd

    // write the flags, then let registered outputs settle
    task automatic cfg(input logic [31:0] d);
        wr(7'h00, d);
        repeat (3) @(posedge clk);
        #1;
    endtask : cfg

    task automatic step;
        @(posedge clk);
        seq_step <= 1'b1;
        @(posedge clk);
        seq_step <= 1'b0;
    endtask : step

    task automatic t_regs;
        rd(7'h00, 32'h0);
        wr(7'h00, 32'hffffffff);
        rd(7'h00, 32'h001ff196);
        wr(7'h05, 32'h0);
        rd(7'h05, 32'h0);
        rd(7'h00, 32'h001ff196);
        // write then read back to back
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= 7'h00;
        reg_wdata <= 32'h00a5a5a5;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge clk);
        reg_rd    <= 1'b0;
        #1 chk(reg_rdata, 32'h0005a184);
    endtask : t_regs

    task automatic t_dir_coil;
        seq_dir <= 1'b1;
        tpos    <= {7'h0, 9'h1f0, 7'h0, 9'h040};
        hold    <= 5'h1f;
        vel_in_pwm_range <= 1'b1;
        cfg(32'h0);
        chk(32'(dir_out), 32'h1);
        chk(32'(coil_a_out), 32'h0aa);
        cfg(32'h1 << GCFG_BIT_SHAFT_INV | 32'h1 << GCFG_BIT_DIRECT | 32'h4);
        chk(32'(dir_out), 32'h0);
        chk(32'(coil_a_out), 32'h040);
        chk(32'(coil_b_out), 32'h1f0);
        chk({pwm_mode_on, pwm_velreg_on, pwm_autoscale_on}, 32'h4);
        hold    <= 5'h00;
        vel_low <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(32'(coil_a_out), 32'h002);
        chk(32'(coil_b_out), 32'h1ff);
        chk(32'(pwm_autoscale_on), 32'h1);
        cfg(32'h4);
        chk({pwm_mode_on, pwm_velreg_on, pwm_autoscale_on}, 32'h7);
        cfg(32'h0);
        chk(32'(pwm_mode_on), 32'h0);
    endtask : t_dir_coil

    // two-cycle pulse, then toggle mode, then interrupt on open collector
    task automatic t_aux0;
        logic v;
        cfg(32'h2 << GCFG_PULSE_LSB | 32'h1080);
        step();
        n = 0;
        repeat (10) begin
            @(posedge clk);
            #1 n += int'(aux0_o === 1'b1);
        end
        chk(n, 2);
        chk(32'(aux0_oe), 32'h1);
        cfg(32'h1080);
        v = aux0_o;
        step();
        repeat (4) @(posedge clk);
        #1 chk(32'(aux0_o), 32'(!v));
        irq_req <= 1'b1;
        cfg(32'h0);
        chk({aux0_o, aux0_oe}, 32'h1);
    endtask : t_aux0

    task automatic t_aux1;
        pos_compare <= 1'b1;
        cfg(32'h0);
        chk({aux1_o, aux1_oe}, 32'h1);
        pos_compare <= 1'b0;
        cfg(32'h2100);
        chk({aux1_o, aux1_oe}, 32'h3);
        uart_active <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk({aux1_o, aux1_oe}, 32'h1);
        uart_active <= 1'b0;
        cfg(32'h2000);
        chk({aux1_o, aux1_oe}, 32'h1);
    endtask : t_aux1

    task automatic t_halt;
        cfg(32'h1 << GCFG_BIT_HALT_EN);
        encoder_a_input <= 1'b1;
        n = 0;
        while (n < 20 && seq_run !== 1'b0) begin
            @(posedge clk);
            #1 n++;
        end
        bound_hit(20);
        chk(n, 3);
        cfg(32'h0);
        chk(32'(seq_run), 32'h1);
        encoder_a_input <= 1'b0;
    endtask : t_halt

    // clocks from the taking edge of a step until standstill rises
    task automatic t_idle(input logic quick, input int lim);
        logic seen_low;
        cfg(32'(quick) << GCFG_BIT_QUICK_IDLE);
        @(posedge clk);
        seq_step <= 1'b1;
        n = 0;
        seen_low = 1'b0;
        while (n < 300 && !(seen_low && standstill === 1'b1)) begin
            @(posedge clk);
            seq_step <= 1'b0;
            #1 n++;
            if (standstill === 1'b0)
                seen_low = 1'b1;
        end
        bound_hit(300);
        chk(n, lim + 3);
    endtask : t_idle

    // 336 sits between the narrow and wide upper limits of 320
    task automatic t_freq;
        freq_thresh <= 20'd320;
        step_freq   <= 20'd336;
        cfg(32'h0);
        chk(32'(freq_above), 32'h0);
        cfg(32'h1 << GCFG_BIT_NARROW_HYST);
        chk(32'(freq_above), 32'h1);
        cfg(32'h0);
        chk(32'(freq_above), 32'h1);
        step_freq   <= 20'd290;
        repeat (3) @(posedge clk);
        #1 chk(32'(freq_above), 32'h0);
    endtask : t_freq

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // main sequence
    initial begin
        fail_count = 0;
        n_tests = 0;
        {rstn, reg_wr, reg_rd, seq_step, seq_dir, vel_in_pwm_range} = '0;
        {vel_low, uart_active, pos_compare, irq_req, encoder_a_input} = '0;
        {reg_addr, reg_wdata, tpos, hold, step_freq, freq_thresh} = '0;
        seq_coil_a = 9'h0aa;
        seq_coil_b = 9'h055;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_dir_coil();
        t_aux0();
        t_aux1();
        t_halt();
        t_idle(1'b1, 16);
        t_idle(1'b0, 64);
        t_freq();
        give_verdict();
    end
endmodule : tb_global_config_register
